/* File: testbench/peg_board_model.sv */
`timescale 1ns/1ps
// board side of the port lines
module peg_board_model (
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe_n,
  input wire logic [3:0] board_level,
  output logic [3:0] line_in
);
  // a driven line shows the device value, else what the board applies
  assign line_in = (~line_oe_n & line_out) | (line_oe_n & board_level);
endmodule : peg_board_model

/* File: testbench/peg_gpio_properties.sv */
`timescale 1ns/1ps
// port-level checks on the gpio block
module peg_gpio_properties (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [3:0] line_in,
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe_n,
  input wire logic [3:0] line_event,
  input wire logic irq_req
);
  // one domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_irq_or_events:
    assert property (irq_req == (|line_event))
    else $error("irq_req differs from or of line events");
  // per line: other lines may legally have edges on the next cycle
  a_event_one_cycle:
    assert property ((line_event & $past(line_event)) == 4'h0)
    else $error("line event wider than one cycle");
  // an event needs a level change three edges back
  a_event_has_edge:
    assert property ((line_event & ~($past(line_in, 3) ^
      $past(line_in, 4))) == 4'h0)
    else $error("line event without an input edge");
  a_reset_idle:
    assert property ($fell(sys_rst) |-> line_oe_n == 4'hF &&
      line_out == 4'h0 && !irq_req)
    else $error("lines not idle inputs after reset");
  a_driver_kept:
    assert property ((line_oe_n & ~$past(line_oe_n)) == 4'h0)
    else $error("line driver turned off without reset");
  a_out_when_driven:
    assert property ($changed(line_out) |->
      (line_oe_n & (line_out ^ $past(line_out))) == 4'h0)
    else $error("line value changed on an undriven line");
  a_sda_low_only:
    assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_sda_steady:
    assert property ($rose(scl_in) |=> $stable(sda_oe_n) [*8])
    else $error("data pin moved while bus clock high");

  c_irq: cover property (irq_req);
  c_ack: cover property ($fell(sda_oe_n));
  c_drive: cover property ($fell(line_oe_n[0]));
endmodule : peg_gpio_properties

bind peg_gpio peg_gpio_properties u_props (.sys_clk, .sys_rst, .scl_in,
  .sda_out, .sda_oe_n, .line_in, .line_out, .line_oe_n, .line_event,
  .irq_req);

/* File: testbench/port_expander_gpio_test.sv */
`timescale 1ns/1ps
// self-checking bench for the gpio block
module port_expander_gpio_test;
  localparam logic [6:0] DEV = 7'h44;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl_in = 1'b1;
  logic sda_drv = 1'b1;
  logic [3:0] board_level = 4'h0;
  logic sda_in, sda_out, sda_oe_n, irq_req, ack;
  logic [3:0] line_in, line_out, line_oe_n, line_event;
  logic [7:0] q;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int irq_cnt = 0;
  int ev_cnt [4] = '{0, 0, 0, 0};

  always #12.5 sys_clk = ~sys_clk;
  // open-drain wire: low when either side pulls
  assign sda_in = sda_drv & (sda_oe_n | sda_out);

  peg_gpio #(.DEV_ADDR(DEV)) DUT (.sys_clk, .sys_rst, .scl_in, .sda_in,
    .sda_out, .sda_oe_n, .line_in, .line_out, .line_oe_n, .line_event,
    .irq_req);
  peg_board_model board (.line_out, .line_oe_n, .board_level, .line_in);

  // event tally; ceiling is about four times the expected run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (!sys_rst) begin
      for (int i = 0; i < 4; i++)
        ev_cnt[i] <= ev_cnt[i] + line_event[i];
      irq_cnt <= irq_cnt + irq_req;
    end
    if (cycles == 60000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_n

  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // start (stop=0) or stop condition; sda moves well off the scl edge
  task automatic frame_edge(input logic stop);
    wait_n(2);
    sda_drv <= ~stop;
    wait_n(8);
    scl_in <= 1'b1;
    wait_n(10);
    sda_drv <= stop;
    wait_n(10);
    if (!stop)
      scl_in <= 1'b0;
  endtask : frame_edge

  // one bus clock carrying bit b; s is the wire mid-high
  task automatic bit_io(input logic b, output logic s);
    wait_n(2);
    sda_drv <= b;
    wait_n(8);
    scl_in <= 1'b1;
    wait_n(5);
    s = sda_in;
    wait_n(5);
    scl_in <= 1'b0;
  endtask : bit_io

  // eight bits msb first plus the ninth bit; ack 0 means acknowledged
  task automatic xfer(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, ack);
  endtask : xfer

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    frame_edge(1'b0);
    xfer({DEV, 1'b0});
    xfer(ptr);
    xfer(d);
    chk("write ack", 8'h00, {7'h0, ack});
    frame_edge(1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp,
    input string what);
    frame_edge(1'b0);
    xfer({DEV, 1'b0});
    xfer(ptr);
    frame_edge(1'b0);
    xfer({DEV, 1'b1});
    xfer(8'hFF);
    frame_edge(1'b1);
    chk(what, exp, q);
  endtask : rd

  // board holds each level well past the minimum input width
  task automatic hold_lines(input logic [3:0] v);
    board_level <= v;
    wait_n(200);
  endtask : hold_lines

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    wait_n(6);
    sys_rst <= 1'b0;
    wait_n(3);
    chk("line_oe_n", 8'h0F, {4'h0, line_oe_n});
    for (logic [7:0] a = 8'h10; a < 8'h15; a++)
      rd(a, 8'h00, "reset value");
    wr(8'h13, 8'hF1);
    wr(8'h14, 8'h02);
    rd(8'h13, 8'h01, "fall enable");
    rd(8'h14, 8'h02, "rise enable");
    $display("test enables finished");
    hold_lines(4'h7);
    hold_lines(4'h0);
    chk("line0 events", 8'h01, ev_cnt[0][7:0]);
    chk("line1 events", 8'h01, ev_cnt[1][7:0]);
    chk("line2 events", 8'h00, ev_cnt[2][7:0]);
    chk("irq pulses", 8'h02, irq_cnt[7:0]);
    $display("test edges finished");
    hold_lines(4'hA);
    rd(8'h12, 8'h0A, "level");
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h0A, "level after write");
    hold_lines(4'h0);
    $display("test monitor finished");
    wr(8'h10, 8'hF5);
    chk("set out", 8'h05, {4'h0, line_out});
    chk("set oe_n", 8'h0A, {4'h0, line_oe_n});
    rd(8'h12, 8'h05, "driven level");
    wr(8'h11, 8'h01);
    chk("clear out", 8'h04, {4'h0, line_out});
    rd(8'h10, 8'h00, "set reads");
    rd(8'h11, 8'h00, "clear reads");
    rd(8'h20, 8'h00, "unmapped");
    frame_edge(1'b0);
    xfer({7'h45, 1'b0});
    chk("foreign ack", 8'h01, {7'h0, ack});
    frame_edge(1'b1);
    $display("test drive finished");
    sys_rst <= 1'b1;
    wait_n(6);
    sys_rst <= 1'b0;
    wait_n(3);
    chk("oe_n after reset", 8'h0F, {4'h0, line_oe_n});
    rd(8'h13, 8'h00, "fall enable after reset");
    $display("test second reset finished");
    wrap_up();
  end
endmodule : port_expander_gpio_test

/* File: verilog/peg_edge.sv */
`timescale 1ns/1ps
// edge detector: compares the present sample with the previous one
module peg_edge #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev_reg;

  // previous sample, reset low so a line held high gives one rise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  // one-cycle pulse per edge
  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule : peg_edge

/* File: verilog/peg_gpio.sv */
// Behaviour
// - reading the level monitor returns each line's present level and writes to it are ignored.
// - a one written to a bit of the set strobe drives that line high, zeros change nothing.
// - a one written to a bit of the clear strobe drives that line low, zeros change nothing.
// - the set and clear strobes always read back as all zeros.
// - with its falling enable bit set, a high-to-low change on a line raises a request.
// - with its rising enable bit set, a low-to-high change on a line raises a request.
// - a line with both edge enables clear never raises a request.
// - after reset every line is an input with its driver off and all registers except the level monitor read zero.
`timescale 1ns/1ps
module peg_gpio
  import peg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h44, // bus address, value arbitrary
  parameter int NUM_LINES = PEG_NUM_LINES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // serial register bus, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // port lines, two-way
  input wire logic [NUM_LINES-1:0] line_in,
  output logic [NUM_LINES-1:0] line_out,
  output logic [NUM_LINES-1:0] line_oe_n,
  // edge events toward the shared interrupt controller
  output logic [NUM_LINES-1:0] line_event,
  output logic irq_req
);

  logic [1:0] bus_n_s;
  logic scl_s;
  logic sda_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  logic [NUM_LINES-1:0] level_s;
  logic [NUM_LINES-1:0] edge_rise;
  logic [NUM_LINES-1:0] edge_fall;

  peg_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_done_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic first_reg;
  logic acked_reg;
  logic sda_oe_n_reg;

  logic wr_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] rd_data;

  logic [NUM_LINES-1:0] out_reg;
  logic [NUM_LINES-1:0] oe_n_reg;
  logic [NUM_LINES-1:0] fall_en_reg;
  logic [NUM_LINES-1:0] rise_en_reg;
  logic [NUM_LINES-1:0] event_reg;
  logic [NUM_LINES-1:0] event_next;
  logic irq_reg;

  // bus pins and port lines come from outside the clock domain;
  // bus pins pass inverted so the zero reset reads as a released bus,
  // otherwise a false clock edge would follow every reset
  peg_sync #(
    .WIDTH(2)
  ) u_bus_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(~{scl_in, sda_in}),
    .sync_out(bus_n_s)
  );
  assign scl_s = ~bus_n_s[1];
  assign sda_s = ~bus_n_s[0];

  // level monitor reads these synchronised samples
  peg_sync #(
    .WIDTH(NUM_LINES)
  ) u_line_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(line_in),
    .sync_out(level_s)
  );

  // edge pulses from successive synchronised samples
  peg_edge #(
    .WIDTH(NUM_LINES)
  ) u_line_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .level(level_s),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  // previous bus samples for start, stop and clock edges
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // released bus idles high, so the reset values cause no false start
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign bus_start = scl_s & scl_prev_reg & ~sda_s & sda_prev_reg;
  assign bus_stop = scl_s & scl_prev_reg & sda_s & ~sda_prev_reg;

  // read data by pointer; strobes and unmapped offsets read zero
  always_comb begin
    rd_data = PEG_READ_ZERO;
    case (ptr_reg)
      PEG_OFS_LEVEL: rd_data[PEG_LINE_MSB:PEG_LINE_LSB] = level_s;
      PEG_OFS_FALL_EN: rd_data[PEG_LINE_MSB:PEG_LINE_LSB] = fall_en_reg;
      PEG_OFS_RISE_EN: rd_data[PEG_LINE_MSB:PEG_LINE_LSB] = rise_en_reg;
      default: rd_data = PEG_READ_ZERO;
    endcase
  end

  // bus engine: address match, pointer byte, auto-incremented data
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= PEG_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      shift_reg <= 8'h00;
      ptr_reg <= PEG_RST_PTR;
      rw_reg <= 1'b0;
      first_reg <= 1'b1;
      acked_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      wr_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_reg <= 1'b0;
      if (bus_start) begin
        // a start, repeated or not, always restarts the address phase
        state_reg <= PEG_ADDR;
        bit_cnt_reg <= 3'h0;
        byte_done_reg <= 1'b0;
        first_reg <= 1'b1;
        sda_oe_n_reg <= 1'b1;
      end else if (bus_stop) begin
        state_reg <= PEG_IDLE;
        sda_oe_n_reg <= 1'b1;
      end else begin
        case (state_reg)
          PEG_IDLE: begin
            sda_oe_n_reg <= 1'b1;
          end
          PEG_ADDR, PEG_WR_BYTE: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              byte_done_reg <= (bit_cnt_reg == 3'h7);
            end else if (scl_fall && byte_done_reg) begin
              byte_done_reg <= 1'b0;
              if (state_reg == PEG_ADDR) begin
                if (shift_reg[7:1] == DEV_ADDR) begin
                  rw_reg <= shift_reg[0];
                  sda_oe_n_reg <= 1'b0;
                  state_reg <= PEG_ADDR_ACK;
                end else begin
                  state_reg <= PEG_IDLE;
                end
              end else begin
                sda_oe_n_reg <= 1'b0;
                state_reg <= PEG_WR_ACK;
                if (first_reg) begin
                  ptr_reg <= shift_reg;
                  first_reg <= 1'b0;
                end else begin
                  wr_reg <= 1'b1;
                  wr_addr_reg <= ptr_reg;
                  wr_data_reg <= shift_reg;
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
            end
          end
          PEG_ADDR_ACK, PEG_WR_ACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (state_reg == PEG_ADDR_ACK && rw_reg) begin
                // first read byte goes out right after the address ack
                shift_reg <= rd_data;
                sda_oe_n_reg <= rd_data[7];
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= PEG_RD_BYTE;
              end else begin
                sda_oe_n_reg <= 1'b1;
                state_reg <= PEG_WR_BYTE;
              end
            end
          end
          PEG_RD_BYTE: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 3'h7) begin
                sda_oe_n_reg <= 1'b1;
                state_reg <= PEG_RD_ACK;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_n_reg <= shift_reg[6];
              end
            end
          end
          PEG_RD_ACK: begin
            if (scl_rise) begin
              acked_reg <= ~sda_s;
            end else if (scl_fall) begin
              if (acked_reg) begin
                bit_cnt_reg <= 3'h0;
                shift_reg <= rd_data;
                sda_oe_n_reg <= rd_data[7];
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= PEG_RD_BYTE;
              end else begin
                // master nack ends the read; wait for stop or start
                state_reg <= PEG_IDLE;
              end
            end
          end
          default: begin
            state_reg <= PEG_IDLE;
            sda_oe_n_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // set and clear strobes steer the line drivers; no register stores them
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_reg <= PEG_RST_LINES;
      oe_n_reg <= '1;
    end else if (wr_reg && wr_addr_reg == PEG_OFS_SET) begin
      out_reg <= out_reg | wr_data_reg[PEG_LINE_MSB:PEG_LINE_LSB];
      oe_n_reg <= oe_n_reg & ~wr_data_reg[PEG_LINE_MSB:PEG_LINE_LSB];
    end else if (wr_reg && wr_addr_reg == PEG_OFS_CLEAR) begin
      out_reg <= out_reg & ~wr_data_reg[PEG_LINE_MSB:PEG_LINE_LSB];
      oe_n_reg <= oe_n_reg & ~wr_data_reg[PEG_LINE_MSB:PEG_LINE_LSB];
    end
  end

  // edge enables; upper data bits are dropped, monitor writes fall away
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fall_en_reg <= PEG_RST_FALL_EN;
      rise_en_reg <= PEG_RST_RISE_EN;
    end else if (wr_reg) begin
      if (wr_addr_reg == PEG_OFS_FALL_EN) begin
        fall_en_reg <= wr_data_reg[PEG_LINE_MSB:PEG_LINE_LSB];
      end
      if (wr_addr_reg == PEG_OFS_RISE_EN) begin
        rise_en_reg <= wr_data_reg[PEG_LINE_MSB:PEG_LINE_LSB];
      end
    end
  end

  // gate edges by their enables; both clear means no request at all
  always_comb begin
    event_next = (edge_fall & fall_en_reg)
               | (edge_rise & rise_en_reg);
  end

  // registered so the outputs come straight from flops, one cycle late
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      event_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      event_reg <= event_next;
      irq_reg <= |event_next;
    end
  end

  // open-drain data only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_reg;
  assign line_out = out_reg;
  assign line_oe_n = oe_n_reg;
  assign line_event = event_reg;
  assign irq_req = irq_reg;

endmodule : peg_gpio

/* File: verilog/peg_pkg.sv */
package peg_pkg;

  // number of port lines and register data width
  localparam int PEG_NUM_LINES = 4;
  localparam int PEG_DATA_W = 8;

  // register offsets on the serial register bus
  localparam logic [7:0] PEG_OFS_SET = 8'h10;
  localparam logic [7:0] PEG_OFS_CLEAR = 8'h11;
  localparam logic [7:0] PEG_OFS_LEVEL = 8'h12;
  localparam logic [7:0] PEG_OFS_FALL_EN = 8'h13;
  localparam logic [7:0] PEG_OFS_RISE_EN = 8'h14;

  // reset values and the fixed read value of the strobe registers
  localparam logic [3:0] PEG_RST_LINES = 4'h0;
  localparam logic [3:0] PEG_RST_FALL_EN = 4'h0;
  localparam logic [3:0] PEG_RST_RISE_EN = 4'h0;
  localparam logic [7:0] PEG_RST_PTR = 8'h00;
  localparam logic [7:0] PEG_READ_ZERO = 8'h00;

  // field layout: bit n is line n, upper bits unused
  localparam int PEG_LINE_LSB = 0;
  localparam int PEG_LINE_MSB = 3;

  // least input width the far side must hold, and its cycle count
  localparam int PEG_CLK_KHZ = 40000;
  localparam int PEG_TIN_US = 4;
  localparam int PEG_TIN_CYCLES = (PEG_TIN_US * PEG_CLK_KHZ + 999) / 1000;

  // serial bus engine states
  typedef enum logic [2:0] {
    PEG_IDLE,
    PEG_ADDR,
    PEG_ADDR_ACK,
    PEG_WR_BYTE,
    PEG_WR_ACK,
    PEG_RD_BYTE,
    PEG_RD_ACK
  } peg_state_t;

endpackage : peg_pkg

/* File: verilog/peg_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for a group of asynchronous levels
module peg_sync #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : peg_sync
